/* logic/wdh_pkg.sv */
// Package for the watchdog and halt control block: map, fields, resets, timing
package wdh_pkg;
	// Register map (byte addresses on the plain register port)
	localparam logic [7:0] WDH_ADDR_COUNT_LO   = 8'hC2;
	localparam logic [7:0] WDH_ADDR_COUNT_HI   = 8'hC3;
	localparam logic [7:0] WDH_ADDR_CONTROL    = 8'hC4;
	localparam logic [7:0] WDH_ADDR_FLAGS      = 8'hFC;
	// Control register fields
	localparam int WDH_CTL_HALT_BIT   = 7;
	localparam int WDH_CTL_SEL_HI     = 6;
	localparam int WDH_CTL_SEL_LO     = 4;
	localparam int WDH_CTL_STOP_BIT   = 3;
	localparam logic [7:0] WDH_CTL_RESET      = 8'hF8;
	localparam logic [7:0] WDH_CTL_UPPER_MASK = 8'hF8;
	// Flags register fields
	localparam int WDH_FLG_TIMEOUT_BIT = 0;
	localparam int WDH_FLG_STOP_BIT    = 1;
	// Counter and prescaler
	localparam int WDH_CNT_W     = 16;
	localparam int WDH_TICK_DIV  = 64;
	localparam int WDH_TICK_W    = 6;
	localparam logic [15:0] WDH_RESTART_VECTOR = 16'h0020;
	localparam logic [7:0]  WDH_OP_HALT        = 8'h7F;
	// Timeout in crystal cycles for select 001; each step doubles
	localparam longint WDH_BASE_TIMEOUT_CYC = 65536;

	typedef enum logic [2:0]
	{
		WDH_RUN  = 3'b001,
		WDH_HALT = 3'b010,
		WDH_STOP = 3'b100
	} wdh_mode_t;

	typedef struct packed
	{
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} wdh_bus_t;

	typedef struct packed
	{
		logic first_instr;
		logic restart;
		logic halt;
		logic stop;
		logic irq;
		logic wake;
	} wdh_core_t;
endpackage

/* logic/wdh_top.sv */
// Watchdog timer, reset-cause flags and halt/stop power-mode control
//
// Overview of operation
// - 16-bit retriggerable one-shot forces reset at terminal
// - Counter advances once per 64 crystal cycles
// - Timeout vectors to 0020H and sets flag
// - Out of reset running with longest timeout
// - Restart reloads count from time-select bits
// - Disable only at first instruction or stop
// - Timeout coinciding with restart still resets
// - Pin reset clears both timeout and stop flags
// - Timeout sets the timeout flag
// - Stop instruction sets stop-recovery flag
// - Flags clear only by explicit software write or pin reset
// - Upper five control bits writable first instruction only
// - Bits 6:4 select timeout, 000 disables
// - Bit 7 allows watchdog reset during halt
// - Bit 3 set blocks entry to stop mode; stop flag still sets
// - Wake from stop sets stop gate again
// - Halt gates core clock, oscillator keeps running
// - Halt entered by opcode 7F alone
// - Interrupt releases halt, resumes after halt
// - Reset or timeout from halt restarts at 0020H
// - Flags in bits 1:0 of register FC
`timescale 1ns/1ps
module wdh_top
(
	// Clock and reset
	input  wire logic                    clk,
	input  wire logic                    rst,
	// Register port
	input  wire wdh_pkg::wdh_bus_t       bus,
	output logic [7:0]                   rdata,
	// Core events
	input  wire wdh_pkg::wdh_core_t      core,
	input  wire logic [7:0]              opcode,
	// Core control
	output logic                         core_clk_en,
	output logic                         wdt_reset,
	output logic [15:0]                  vector_pc,
	output logic                         halted,
	output logic                         stopped
);
	import wdh_pkg::*;

	logic [7:0]               ctl_r;
	logic [7:0]               ctl_nxt;
	logic [1:0]               flags_r;
	logic [1:0]               flags_nxt;
	logic [WDH_CNT_W-1:0]     cnt_r;
	logic [WDH_CNT_W-1:0]     cnt_nxt;
	logic [WDH_TICK_W-1:0]    pre_r;
	logic                     first_r;
	logic                     first_seen_r;
	logic                     wdt_reset_r;
	logic [7:0]               rdata_r;
	wdh_mode_t                mode_r;
	wdh_mode_t                mode_nxt;

	// Reload value: count of 64-cycle ticks giving 65536 << (sel-1) cycles
	function automatic logic [WDH_CNT_W-1:0] reload_of(input logic [2:0] sel);
		logic [WDH_CNT_W-1:0] v;
		v = '0;
		if (sel != 3'd0)
			v = WDH_CNT_W'((WDH_BASE_TIMEOUT_CYC / WDH_TICK_DIV) << (sel - 3'd1)) - 16'h0001;
		return v;
	endfunction

	wire [2:0] sel        = ctl_r[WDH_CTL_SEL_HI:WDH_CTL_SEL_LO];
	wire       wdt_on     = (sel != 3'd0) && (mode_r != WDH_STOP);
	wire       tick       = (pre_r == 6'(WDH_TICK_DIV - 1));
	wire       terminal   = wdt_on && tick && (cnt_r == 16'h0000);
	wire       halt_ok    = ctl_r[WDH_CTL_HALT_BIT] || (mode_r != WDH_HALT);
	wire       timeout    = terminal && halt_ok;
	wire       wr_ctl     = bus.wr && (bus.addr == WDH_ADDR_CONTROL);
	wire       wr_flags   = bus.wr && (bus.addr == WDH_ADDR_FLAGS);
	wire       halt_cmd   = core.halt && (opcode == WDH_OP_HALT);
	wire       stop_cmd   = core.stop && !ctl_r[WDH_CTL_STOP_BIT];

	// Upper five bits only in the first instruction; bits 2:0 always writable
	always_comb
	begin
		ctl_nxt = ctl_r;
		if (wr_ctl)
		begin
			if (first_r && core.first_instr)
				ctl_nxt = bus.wdata;
			else
				ctl_nxt = {ctl_r[7:3], bus.wdata[2:0]};
		end
		if (mode_r == WDH_STOP && core.wake)
			ctl_nxt[WDH_CTL_STOP_BIT] = 1'b1;
	end

	// Hardware set wins over a same-cycle software clear
	always_comb
	begin
		flags_nxt = flags_r;
		if (wr_flags)
			flags_nxt = bus.wdata[1:0];
		if (timeout)
			flags_nxt[WDH_FLG_TIMEOUT_BIT] = 1'b1;
		if (core.stop)
			flags_nxt[WDH_FLG_STOP_BIT] = 1'b1;
	end

	// A restart in the terminal cycle does not rescue the part
	always_comb
	begin
		cnt_nxt = cnt_r;
		if (core.restart || timeout)
			cnt_nxt = reload_of(sel);
		else if (wdt_on && tick && cnt_r != 16'h0000)
			cnt_nxt = cnt_r - 16'h0001;
	end

	always_comb
	begin
		mode_nxt = mode_r;
		case (mode_r)
			WDH_RUN:
				if (stop_cmd)
					mode_nxt = WDH_STOP;
				else if (halt_cmd)
					mode_nxt = WDH_HALT;
			WDH_HALT:
				if (core.irq || timeout)
					mode_nxt = WDH_RUN;
			WDH_STOP:
				if (core.wake)
					mode_nxt = WDH_RUN;
			default:
				mode_nxt = WDH_RUN;
		endcase
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			ctl_r   <= WDH_CTL_RESET;
			flags_r      <= 2'b00;
			first_r      <= 1'b1;
			first_seen_r <= 1'b0;
		end
		else
		begin
			ctl_r        <= ctl_nxt;
			flags_r      <= flags_nxt;
			first_seen_r <= core.first_instr;
			// The window closes once the first instruction has ended, not when it starts
			if (first_seen_r && !core.first_instr)
				first_r <= 1'b0;
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			cnt_r  <= 16'hFFFF;
			pre_r  <= '0;
			mode_r <= WDH_RUN;
		end
		else
		begin
			cnt_r  <= cnt_nxt;
			pre_r  <= (mode_r == WDH_STOP) ? '0 : pre_r + 6'd1;
			mode_r <= mode_nxt;
		end
	end

	wire [7:0] rd_mux = (bus.addr == WDH_ADDR_COUNT_LO) ? cnt_r[7:0] :
	                    (bus.addr == WDH_ADDR_COUNT_HI) ? cnt_r[15:8] :
	                    (bus.addr == WDH_ADDR_CONTROL)  ? ctl_r :
	                    (bus.addr == WDH_ADDR_FLAGS)    ? {6'b000000, flags_r} : 8'h00;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			rdata_r     <= 8'h00;
			wdt_reset_r <= 1'b0;
		end
		else
		begin
			rdata_r     <= bus.rd ? rd_mux : 8'h00;
			wdt_reset_r <= timeout;
		end
	end

	assign rdata       = rdata_r;
	assign wdt_reset   = wdt_reset_r;
	assign vector_pc   = WDH_RESTART_VECTOR;
	assign halted      = mode_r[1];
	assign stopped     = mode_r[2];
	assign core_clk_en = mode_r[0];

	a_timeout_flag: assert property (@(posedge clk) disable iff (rst) timeout |=> flags_r[0] && wdt_reset)
		else $error("timeout did not set flag and reset");
	a_restart_race: assert property (@(posedge clk) disable iff (rst) (timeout && core.restart) |=> wdt_reset)
		else $error("restart masked a timeout");
	a_upper_locked: assert property (@(posedge clk) disable iff (rst)
		(!first_r && !(mode_r == WDH_STOP && core.wake)) |=> ctl_r[7:3] == $past(ctl_r[7:3]))
		else $error("upper control bits changed after first instruction");
	a_tick_spacing: assert property (@(posedge clk) disable iff (rst)
		(wdt_on && tick && !core.restart && cnt_r != 0) |=> !tick[*8])
		else $error("counter ticks too often");
	a_stop_noop: assert property (@(posedge clk) disable iff (rst)
		(mode_r == WDH_RUN && core.stop && ctl_r[3]) |=> mode_r != WDH_STOP)
		else $error("stop entered while gated");
	a_wake_regate: assert property (@(posedge clk) disable iff (rst)
		(mode_r == WDH_STOP && core.wake) |=> ctl_r[3] && mode_r == WDH_RUN)
		else $error("wake did not regate stop");
	a_halt_quiet: assert property (@(posedge clk) disable iff (rst)
		(mode_r == WDH_HALT && !ctl_r[7]) |=> !wdt_reset)
		else $error("watchdog reset during halt while suppressed");
	a_stop_flag: assert property (@(posedge clk) disable iff (rst) core.stop |=> flags_r[1])
		else $error("stop did not set recovery flag");
	a_halt_clock: assert property (@(posedge clk) disable iff (rst) halt_cmd && mode_r == WDH_RUN && !stop_cmd
		|=> !core_clk_en ##0 halted)
		else $error("halt did not gate core clock");
endmodule

/* tb/wdh_core_model.sv */
// Behavioural processor core issuing watchdog, halt and stop events
`timescale 1ns/1ps
module wdh_core_model
(
	// Clock
	input  wire logic          clk,
	// Core events
	output wdh_pkg::wdh_core_t core,
	output logic [7:0]         opcode
);
	import wdh_pkg::*;

	initial
	begin
		core = '0;
		opcode = 8'h00;
	end

	// Level held for the whole first instruction
	task automatic set_first(input logic v);
		@(posedge clk);
		core.first_instr <= v;
	endtask

	// One-cycle event: bit 4 restart, 3 halt, 2 stop, 1 interrupt, 0 wake
	task automatic ev(input int b, input logic [7:0] op);
		@(posedge clk);
		core <= wdh_core_t'(6'h01 << b);
		opcode <= op;
		@(posedge clk);
		core <= '0;
		opcode <= 8'h00;
	endtask
endmodule

/* tb/wdh_top_tb.sv */
// Self-checking bench for the watchdog and halt control block
`timescale 1ns/1ps
module wdh_top_tb;
	import wdh_pkg::*;
	logic        clk;
	logic        rst;
	wdh_bus_t    bus;
	logic [7:0]  rdata;
	wdh_core_t   core;
	logic [7:0]  opcode;
	logic        core_clk_en;
	logic        wdt_reset;
	logic [15:0] vector_pc;
	logic        halted;
	logic        stopped;
	logic        rd_d;
	logic [7:0]  exp_q[$];
	logic [31:0] seed;
	int          fails;
	int          tests_run;
	int          n;

	wdh_top i_wdh_top (.clk(clk), .rst(rst), .bus(bus), .rdata(rdata), .core(core), .opcode(opcode),
		.core_clk_en(core_clk_en), .wdt_reset(wdt_reset), .vector_pc(vector_pc), .halted(halted),
		.stopped(stopped));
	wdh_core_model i_wdh_core_model (.clk(clk), .core(core), .opcode(opcode));

	always #5 clk = ~clk;

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			fails++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic print_verdict;
		$display("Checks %0d, mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge clk);
		bus <= '0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		@(posedge clk);
		bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge clk);
		bus <= '0;
	endtask

	// Read data stand only in the cycle after the strobe
	always @(posedge clk)
	begin
		rd_d <= bus.rd;
		if (rd_d === 1'b1)
			cmp({8'h00, rdata}, {8'h00, exp_q.pop_front()});
	end

	initial
	begin
		#1_000_000;
		fails++;
		print_verdict;
	end

	initial
	begin
		clk = 1'b0;
		rst = 1'b1;
		bus = '0;
		rd_d = 1'b0;
		seed = 32'h0000_996e;
		fails = 0;
		tests_run = 0;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		#1;
		cmp({15'h0000, core_clk_en}, 16'h0001);
		rd(WDH_ADDR_CONTROL, WDH_CTL_RESET);
		rd(WDH_ADDR_FLAGS, 8'h00);
		i_wdh_core_model.set_first(1'b1);
		wr(WDH_ADDR_CONTROL, 8'h10);
		i_wdh_core_model.set_first(1'b0);
		wr(WDH_ADDR_CONTROL, 8'hF8);
		rd(WDH_ADDR_CONTROL, 8'h10);
		i_wdh_core_model.ev(4, 8'h00);
		rd(WDH_ADDR_COUNT_HI, 8'h03);
		i_wdh_core_model.ev(2, 8'h00);
		#1;
		cmp({15'h0000, stopped}, 16'h0001);
		i_wdh_core_model.ev(0, 8'h00);
		#1;
		cmp({15'h0000, stopped}, 16'h0000);
		rd(WDH_ADDR_CONTROL, 8'h18);
		rd(WDH_ADDR_FLAGS, 8'h02);
		rd(WDH_ADDR_FLAGS, 8'h02);
		wr(WDH_ADDR_FLAGS, 8'h00);
		rd(WDH_ADDR_FLAGS, 8'h00);
		i_wdh_core_model.ev(2, 8'h00);
		#1;
		cmp({15'h0000, stopped}, 16'h0000);
		i_wdh_core_model.ev(3, 8'h00);
		#1;
		cmp({15'h0000, halted}, 16'h0000);
		i_wdh_core_model.ev(3, WDH_OP_HALT);
		#1;
		cmp({14'h0000, halted, core_clk_en}, 16'h0002);
		i_wdh_core_model.ev(1, 8'h00);
		#1;
		cmp({14'h0000, halted, core_clk_en}, 16'h0001);
		// Count registers ignore writes; unmapped places read as zero
		repeat (4)
		begin
			seed = lfsr(seed);
			wr(WDH_ADDR_COUNT_LO, seed[15:8]);
			rd(seed[7:0] & 8'h7F, 8'h00);
		end
		rd(WDH_ADDR_COUNT_HI, 8'h03);
		i_wdh_core_model.ev(4, 8'h00);
		n = 0;
		while (wdt_reset !== 1'b1 && n < 70000)
		begin
			@(posedge clk);
			#1;
			n++;
		end
		cmp(16'(n >= 65472 && n <= 65540), 16'h0001);
		@(posedge clk);
		#1;
		cmp({15'h0000, wdt_reset}, 16'h0000);
		cmp(vector_pc, 16'h0020);
		rd(WDH_ADDR_FLAGS, 8'h03);
		repeat (3) @(posedge clk);
		print_verdict;
	end
endmodule
